// *** design/ccp_pkg.sv ***
// Package of constants and types for the configuration control pin logic.
package ccp_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  // ==========================================================================
  localparam logic [11:0] CCP_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] CCP_STATUS_ADDR = 12'h004;
  localparam logic [11:0] CCP_RBDATA_ADDR = 12'h008;
  localparam logic [11:0] CCP_FRAME_ADDR  = 12'h00c;

  // Control fields.
  localparam int CTRL_DONE_LATE_BIT = 0;
  localparam int CTRL_RB_OPT_LO     = 1;
  localparam int CTRL_CFG_END_BIT   = 3;
  localparam int CTRL_USER_IO_BIT   = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ         = 40_000_000;
  localparam int OSC_HZ         = 1_000_000;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam int PON_SHORT_LOG2 = 14;
  localparam int PON_LONG_LOG2  = 16;
  localparam int PWR_UP_OSC     = 2;
  localparam int RESET_MIN_OSC  = 3;
  localparam int STOP_BITS      = 3;

  // Readback options chosen at configuration time.
  typedef enum logic [1:0] {
    RB_REPEAT = 2'b00,
    RB_ONCE   = 2'b01,
    RB_NEVER  = 2'b10
  } ccp_rb_opt_t;

  // Configuration modes from the three mode lines.
  localparam logic [2:0] MODE_SLAVE = 3'b111;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_PON   = 3'b000,
    ST_CLEAR = 3'b001,
    ST_WAIT  = 3'b010,
    ST_CFG   = 3'b011,
    ST_START = 3'b100,
    ST_USER  = 3'b101,
    ST_ERROR = 3'b110
  } ccp_state_t;

endpackage : ccp_pkg

// *** design/ccp_top.sv ***
// Configuration control pin sequencer with an APB register slave.
//
// The address map and register access over APB are this design's own decisions.
module ccp_top
  import ccp_pkg::*;
#(
  parameter int PON_SHORT = 2 ** PON_SHORT_LOG2, // Power-on delay with mode 0 high.
  parameter int PON_LONG  = 2 ** PON_LONG_LOG2,  // Power-on delay with mode 0 low.
  parameter int FRAME_LEN = 16                   // Bits per frame including stop bits.
) (
  input  wire logic        pclk,                 // APB clock, 40 MHz.
  input  wire logic        presetn,              // Asynchronous reset, active low.
  input  wire logic        psel,                 // APB select.
  input  wire logic        penable,              // APB enable.
  input  wire logic        pwrite,               // APB direction.
  input  wire logic [11:0] paddr,                // APB byte address.
  input  wire logic [31:0] pwdata,               // APB write data.
  output logic      [31:0] prdata,               // APB read data.
  output logic             pready,               // APB ready.
  output logic             pslverr,              // APB error, unmapped address.
  input  wire logic        power_down_n,         // Power-down pin, active low.
  input  wire logic        reset_n,              // Reset pin, active low.
  input  wire logic        config_clock_in,      // Config clock pin level.
  output logic             config_clock_out,     // Config clock drive value.
  output logic             config_clock_oe,      // Config clock drive enable.
  input  wire logic        done_program_in,      // Done/program pin level.
  output logic             done_program_oe,      // Open-drain pull-down enable.
  input  wire logic        mode_sel0_readback_trigger, // Mode 0 and readback trigger.
  input  wire logic        mode_sel1_in,         // Mode 1 pin level.
  output logic             mode_sel1_readback_data_n, // Readback data, active low.
  output logic             mode_sel1_oe,         // Mode 1 drive enable.
  input  wire logic        mode_sel2,            // Mode 2 pin level.
  output logic             mode_sel2_pullup,     // Weak pull-up enable on mode 2.
  input  wire logic        config_data_in,       // Serial configuration data.
  output logic             high_during_config,   // High while configuring.
  output logic             low_during_config,    // Low while configuring.
  output logic             init_oe,              // Clearing-status pull-down enable.
  output logic             outputs_active,       // User outputs enabled.
  output logic             user_clear_n,         // User storage clear, active low.
  output logic             user_io_release       // Status pins handed to user.
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [1:0] pd_sync_q, rst_sync_q, trig_sync_q, config_clock_sync_q, dp_sync_q, din_sync_q;
  logic [1:0] m1_sync_q, m2_sync_q;
  logic       trig_last_q, config_clock_last_q, dp_last_q;

  // two-stage sync. Unpowered inputs read high during power-down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_sync_q   <= 2'b00;
      rst_sync_q  <= 2'b00;
      trig_sync_q <= 2'b00;
      config_clock_sync_q <= 2'b11;
      dp_sync_q   <= 2'b11;
      din_sync_q  <= 2'b11;
      m1_sync_q   <= 2'b11;
      m2_sync_q   <= 2'b11;
    end else begin
      pd_sync_q   <= {pd_sync_q[0], power_down_n};
      rst_sync_q  <= {rst_sync_q[0], reset_n};
      trig_sync_q <= {trig_sync_q[0], mode_sel0_readback_trigger};
      config_clock_sync_q <= {config_clock_sync_q[0], config_clock_in};
      dp_sync_q   <= {dp_sync_q[0], done_program_in};
      din_sync_q  <= {din_sync_q[0], config_data_in};
      m1_sync_q   <= {m1_sync_q[0], mode_sel1_in};
      m2_sync_q   <= {m2_sync_q[0], mode_sel2};
    end
  end

  // inputs as high while powered down.
  logic pd_active, rst_lvl, trig_lvl, m1_lvl, m2_lvl, din_lvl, config_clock_lvl, dp_lvl;
  assign pd_active = !pd_sync_q[1];
  assign rst_lvl   = pd_active | rst_sync_q[1];
  assign trig_lvl  = pd_active | trig_sync_q[1];
  assign m1_lvl    = pd_active | m1_sync_q[1];
  assign m2_lvl    = pd_active | m2_sync_q[1];
  assign din_lvl   = pd_active | din_sync_q[1];
  assign config_clock_lvl  = pd_active | config_clock_sync_q[1];
  assign dp_lvl    = pd_active | dp_sync_q[1];

  // Edge history for the edge detectors, read from the second stage only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_last_q <= 1'b1;
      config_clock_last_q <= 1'b1;
      dp_last_q   <= 1'b1;
    end else begin
      trig_last_q <= trig_lvl;
      config_clock_last_q <= config_clock_lvl;
      dp_last_q   <= dp_lvl;
    end
  end

  logic config_clock_rise, config_clock_fall, trig_rise, dp_fall;
  assign config_clock_rise = config_clock_lvl & !config_clock_last_q;
  assign config_clock_fall = !config_clock_lvl & config_clock_last_q;
  assign trig_rise = trig_lvl & !trig_last_q;
  assign dp_fall   = !dp_lvl & dp_last_q;

  // ==========================================================================
  // Internal 1 MHz oscillator tick
  // ==========================================================================
  logic [7:0] osc_cnt_q;
  logic       osc_tick;
  assign osc_tick = (osc_cnt_q == 8'(OSC_DIV - 1));

  // The oscillator stops while powered down, so its count restarts from zero on release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_q <= 8'h00;
    end else if (pd_active || osc_tick) begin
      osc_cnt_q <= 8'h00;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [31:0] ctrl_q;
  logic [31:0] rb_data_q;
  logic [15:0] frame_cnt_q;
  logic        m0_strap_q, strap_done_q;
  logic [2:0]  mode_q;
  ccp_state_t  state_q;

  // Control is written only at the completing access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == CCP_CTRL_ADDR) begin
      ctrl_q <= pwdata;
    end
  end

  // Zero-wait slave: ready is asserted combinationally-free from a register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == CCP_CTRL_ADDR || paddr == CCP_STATUS_ADDR ||
                 paddr == CCP_RBDATA_ADDR || paddr == CCP_FRAME_ADDR);
      unique case (paddr)
        CCP_CTRL_ADDR:   prdata <= ctrl_q;
        CCP_STATUS_ADDR: prdata <= {25'h0, mode_q, m0_strap_q, state_q};
        CCP_RBDATA_ADDR: prdata <= rb_data_q;
        CCP_FRAME_ADDR:  prdata <= {16'h0000, frame_cnt_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  logic        done_late;
  ccp_rb_opt_t rb_opt;
  assign done_late = ctrl_q[CTRL_DONE_LATE_BIT];
  assign rb_opt    = ccp_rb_opt_t'(ctrl_q[CTRL_RB_OPT_LO +: 2]);

  // ==========================================================================
  // Power-on strap and sequencer
  // ==========================================================================
  // mode 0 sampled once after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_strap_q   <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && !pd_active) begin
      m0_strap_q   <= trig_lvl;
      strap_done_q <= 1'b1;
    end
  end

  logic [16:0] tmr_q;
  logic [1:0]  rst_cnt_q;
  logic [1:0]  seq_q;
  logic [2:0]  stop_q;
  logic        rb_used_q;

  function automatic logic [16:0] pon_delay(input logic m0);
    pon_delay = m0 ? 17'(PON_SHORT) : 17'(PON_LONG);
  endfunction : pon_delay

  // Sequencer: power-on, clear, wait for reset, load, start-up, user, error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_PON;
      tmr_q       <= 17'h0;
      rst_cnt_q   <= 2'b00;
      mode_q      <= 3'b000;
      frame_cnt_q <= 16'h0000;
      stop_q      <= 3'b000;
      seq_q       <= 2'b00;
    end else if (pd_active) begin
      // halts progress; configuration state is retained.
      tmr_q <= 17'h0;
    end else begin
      // count reset low in oscillator ticks.
      if (rst_lvl) begin
        rst_cnt_q <= 2'b00;
      end else if (osc_tick && rst_cnt_q != 2'(RESET_MIN_OSC)) begin
        rst_cnt_q <= rst_cnt_q + 2'b01;
      end
      unique case (state_q)
        ST_PON: begin
          if (strap_done_q && osc_tick) begin
            tmr_q <= tmr_q + 17'h1;
            if (tmr_q + 17'h1 >= pon_delay(m0_strap_q)) begin
              state_q <= ST_CLEAR;
              tmr_q   <= 17'h0;
            end
          end
        end
        ST_CLEAR: begin
          if (osc_tick) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // hold off while reset low. sample mode lines.
          if (rst_lvl) begin
            mode_q      <= {m2_lvl, m1_lvl, trig_lvl};
            frame_cnt_q <= 16'h0000;
            stop_q      <= 3'b000;
            state_q     <= ST_CFG;
          end
        end
        ST_CFG: begin
          if (rst_cnt_q == 2'(RESET_MIN_OSC)) begin
            state_q <= ST_CLEAR;
          end else if (config_clock_rise) begin
            stop_q      <= {stop_q[1:0], din_lvl};
            frame_cnt_q <= frame_cnt_q + 16'h0001;
            if (frame_cnt_q[7:0] == 8'(FRAME_LEN - 1)) begin
              // stop bit check at frame end.
              if ({stop_q[1:0], din_lvl} != {STOP_BITS{1'b1}}) begin
                state_q <= ST_ERROR;
              end else if (ctrl_q[CTRL_CFG_END_BIT]) begin
                state_q <= ST_START;
                seq_q   <= 2'b00;
              end
              frame_cnt_q[7:0] <= 8'h00;
            end
          end
        end
        ST_START: begin
          // synchronous start-up steps on config clock.
          if (config_clock_rise) begin
            seq_q <= seq_q + 2'b01;
            if (seq_q == 2'b10) begin
              state_q <= ST_USER;
            end
          end
        end
        ST_USER: begin
          if (dp_fall && !done_program_oe) begin
            state_q <= ST_CLEAR;
          end
        end
        ST_ERROR: begin
          // Only a qualified reset leaves the error state.
          if (rst_cnt_q == 2'(RESET_MIN_OSC)) begin
            state_q <= ST_CLEAR;
          end
        end
        default: state_q <= ST_PON;
      endcase
    end
  end

  logic configuring;
  assign configuring = (state_q != ST_USER);

  // ==========================================================================
  // Power-down release hold on done
  // ==========================================================================
  logic [1:0] pd_hold_q;

  // two oscillator periods of done low after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_hold_q <= 2'b00;
    end else if (pd_active) begin
      pd_hold_q <= 2'(PWR_UP_OSC);
    end else if (osc_tick && pd_hold_q != 2'b00) begin
      pd_hold_q <= pd_hold_q - 2'b01;
    end
  end

  // ==========================================================================
  // Readback
  // ==========================================================================
  logic rb_run_q;

  // trigger gated by option; shift on config clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_run_q  <= 1'b0;
      rb_used_q <= 1'b0;
      rb_data_q <= 32'h0000_0000;
    end else if (state_q != ST_USER) begin
      rb_run_q  <= 1'b0;
      rb_used_q <= 1'b0;
    end else if (trig_rise && !rb_run_q && rb_opt != RB_NEVER &&
                 !(rb_opt == RB_ONCE && rb_used_q)) begin
      rb_run_q  <= 1'b1;
      rb_used_q <= 1'b1;
      rb_data_q <= {16'h0000, frame_cnt_q};
    end else if (rb_run_q && config_clock_fall) begin
      rb_data_q <= {1'b0, rb_data_q[31:1]};
      rb_run_q  <= (rb_data_q[31:1] != 31'h0);
    end
  end

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  logic [3:0] cdiv_q;
  logic       config_clock_q;

  // Master clock divider for master and peripheral modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdiv_q <= 4'h0;
      config_clock_q <= 1'b1;
    end else begin
      cdiv_q <= cdiv_q + 4'h1;
      if (cdiv_q == 4'hf) begin
        config_clock_q <= !config_clock_q;
      end
    end
  end

  // All pin drives are registered; power-down releases the clock, mode 1 and init drives but holds done low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_clock_out          <= 1'b1;
      config_clock_oe           <= 1'b0;
      done_program_oe           <= 1'b1;
      mode_sel1_readback_data_n <= 1'b1;
      mode_sel1_oe              <= 1'b0;
      mode_sel2_pullup          <= 1'b1;
      high_during_config        <= 1'b1;
      low_during_config         <= 1'b0;
      init_oe                   <= 1'b1;
      outputs_active            <= 1'b0;
      user_clear_n              <= 1'b0;
      user_io_release           <= 1'b0;
    end else begin
      // clock driven in load and start-up unless slave; input in other states.
      config_clock_out <= config_clock_q;
      config_clock_oe  <= !pd_active && (state_q == ST_CFG || state_q == ST_START) &&
                          mode_q != MODE_SLAVE;
      // done order set by control; held low after power-down.
      done_program_oe <= pd_active || pd_hold_q != 2'b00 || configuring &&
                         !(state_q == ST_START && seq_q >= (done_late ? 2'b10 : 2'b01));
      // readback data active low on mode 1 pin.
      mode_sel1_readback_data_n <= !rb_data_q[0];
      mode_sel1_oe              <= !pd_active && rb_run_q && state_q == ST_USER;
      mode_sel2_pullup   <= configuring && !pd_active;
      high_during_config <= configuring;
      low_during_config  <= !configuring;
      // clearing-status low in power-on, clear and error.
      init_oe <= !pd_active && (state_q == ST_PON || state_q == ST_CLEAR ||
                 state_q == ST_ERROR);
      // outputs go active at step one of start-up with done late, step two otherwise.
      outputs_active <= !pd_active && (state_q == ST_USER ||
                        state_q == ST_START && seq_q >= (done_late ? 2'b01 : 2'b10));
      // user storage cleared by raw reset, power-down, or config.
      user_clear_n    <= reset_n && !pd_active && !configuring;
      user_io_release <= !configuring && ctrl_q[CTRL_USER_IO_BIT] && !pd_active;
    end
  end

endmodule : ccp_top

// *** verif/ccp_checker.sv ***
// Port checker of the configuration control pin sequencer.
module ccp_checker (
  input wire logic pclk,               // Clock.
  input wire logic presetn,            // Reset, active low.
  input wire logic psel,               // APB select.
  input wire logic penable,            // APB enable.
  input wire logic pready,             // APB ready.
  input wire logic power_down_n,       // Power-down pin.
  input wire logic reset_n,            // Reset pin.
  input wire logic config_clock_oe,    // Clock drive enable.
  input wire logic done_program_oe,    // Done pull-down.
  input wire logic mode_sel1_oe,       // Readback drive.
  input wire logic high_during_config, // Busy high.
  input wire logic low_during_config,  // Busy low.
  input wire logic outputs_active,     // Outputs live.
  input wire logic user_clear_n        // User clear.
);
  // ==========
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] pd_q;
  // Cycles since power-down release; saturation stops the window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pd_q <= 8'hff;
    else if (!power_down_n) pd_q <= 8'h00;
    else if (pd_q != 8'hff) pd_q <= pd_q + 8'h01;
  end
  a_busy_levels: assert property (!outputs_active && pd_q == 8'hff |->
    high_during_config && !low_during_config) else $error("busy pins wrong");
  a_done_order: assert property ($rose(outputs_active) && pd_q == 8'hff |->
    ##[0:30] !done_program_oe) else $error("done not released near outputs");
  a_pwrup_done: assert property (pd_q inside {[8'd5:8'd40]} |-> done_program_oe)
    else $error("done released too early");
  a_user_clear: assert property (outputs_active && !reset_n |=> !user_clear_n)
    else $error("user storage not cleared");
  a_slave_clock: assert property (config_clock_oe |-> high_during_config)
    else $error("clock driven after load");
  a_rb_pin: assert property (mode_sel1_oe |-> outputs_active)
    else $error("readback pin driven early");
  a_pd_float: assert property (!power_down_n [*6] |-> !outputs_active)
    else $error("outputs live in power-down");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  c_loaded: cover property ($rose(outputs_active));
  c_readback: cover property ($rose(mode_sel1_oe));
  c_access: cover property (pready);
endmodule : ccp_checker

bind ccp_top ccp_checker i_ccp_checker (.pclk, .presetn, .psel, .penable, .pready,
  .power_down_n, .reset_n, .config_clock_oe, .done_program_oe, .mode_sel1_oe,
  .high_during_config, .low_during_config, .outputs_active, .user_clear_n);

// *** verif/ccp_partner.sv ***
// Serial configuration source model.
module ccp_partner (
  input  wire logic pclk,   // Bench clock that paces the link.
  output logic      config_clock_p, // Config clock drive.
  output logic      data_p  // Serial data drive.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // clock parked high
  initial begin
    config_clock_p = 1'b1;
    data_p = 1'b0;
  end
  // 200 ns period, changed only just after a bench clock edge.
  task automatic shift(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      config_clock_p <= 1'b0;
      data_p <= bits[i];
      repeat (4) @(posedge pclk);
      config_clock_p <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    // A released line must not keep a stale bit; one edge keeps calls apart.
    data_p <= ~bits[0];
    @(posedge pclk);
  endtask : shift
endmodule : ccp_partner

// *** verif/ccp_top_tb.sv ***
// Self-checking bench of the configuration control pin sequencer.
module ccp_top_tb
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // power-down held high during load
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic power_down_n = 1'b1, reset_n = 1'b0, mode_sel0_readback_trigger = 1'b1;
  logic mode_sel2 = 1'b1, dp_pull = 1'b0, rb_seen = 1'b0, pready, pslverr, config_clock_p;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic config_clock_out, config_clock_oe, done_program_oe, mode_sel1_readback_data_n;
  logic mode_sel1_oe, mode_sel2_pullup, config_data_in, high_during_config, err;
  logic low_during_config, init_oe, outputs_active, user_clear_n, user_io_release;
  int n_fail = 0, compares = 0, cyc = 0;
  wire config_clock_in = config_clock_oe ? config_clock_out : config_clock_p;
  wire mode_sel1_in = mode_sel1_oe ? mode_sel1_readback_data_n : 1'b1; // Strap resistor.
  wire done_program_in = !(done_program_oe | dp_pull); // Open drain with pull-up.
  ccp_top #(.PON_SHORT(4), .PON_LONG(8), .FRAME_LEN(16)) i_ccp_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_down_n, .reset_n, .config_clock_in, .config_clock_out, .config_clock_oe,
    .done_program_in, .done_program_oe, .mode_sel0_readback_trigger, .mode_sel1_in,
    .mode_sel1_readback_data_n, .mode_sel1_oe, .mode_sel2, .mode_sel2_pullup,
    .config_data_in, .high_during_config, .low_during_config, .init_oe, .outputs_active,
    .user_clear_n, .user_io_release);
  ccp_partner i_ccp_partner (.pclk(pclk), .config_clock_p(config_clock_p), .data_p(config_data_in));
  // Clock, readback watch and hang limit.
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (mode_sel1_oe === 1'b1) rb_seen <= 1'b1;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request stands until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_state(input ccp_state_t s);
    rd = 'x;
    for (int i = 0; i < 3000 && rd[2:0] !== s; i++) apb(1'b0, CCP_STATUS_ADDR, 32'h0);
  endtask : wait_state
  task automatic t_regs();
    apb(1'b0, CCP_CTRL_ADDR, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b1, CCP_CTRL_ADDR, 32'h0000_0009);
    apb(1'b0, CCP_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask : t_regs
  task automatic t_boot();
    repeat (800) @(posedge pclk);
    apb(1'b0, CCP_STATUS_ADDR, 32'h0);
    chk(rd[2:0], ST_WAIT);
    reset_n <= 1'b1;
    wait_state(ST_CFG);
    chk(rd[6:0], {MODE_SLAVE, 1'b1, ST_CFG});
    chk({high_during_config, low_during_config, config_clock_oe, mode_sel2_pullup,
      done_program_oe, init_oe}, 6'b100110);
  endtask : t_boot
  task automatic t_bad();
    i_ccp_partner.shift(32'h0, 16);
    wait_state(ST_ERROR);
    chk({rd[2:0], init_oe}, {ST_ERROR, 1'b1});
    reset_n <= 1'b0;
    repeat (200) @(posedge pclk);
    reset_n <= 1'b1;
    wait_state(ST_CFG);
    chk(rd[2:0], ST_CFG);
  endtask : t_bad
  task automatic t_load();
    // A reset shorter than three timer cycles must not abort the load.
    reset_n <= 1'b0;
    repeat (70) @(posedge pclk);
    reset_n <= 1'b1;
    apb(1'b0, CCP_STATUS_ADDR, 32'h0);
    chk(rd[2:0], ST_CFG);
    apb(1'b1, CCP_CTRL_ADDR, 32'h0000_0009);
    i_ccp_partner.shift(32'h6007, 16);
    i_ccp_partner.shift(32'hf, 4);
    wait_state(ST_USER);
    chk({rd[2:0], outputs_active, done_program_oe}, {ST_USER, 2'b10});
  endtask : t_load
  task automatic t_rb(input logic [31:0] ctrl, input logic exp);
    apb(1'b1, CCP_CTRL_ADDR, ctrl);
    rb_seen = 1'b0;
    mode_sel0_readback_trigger <= 1'b0;
    repeat (10) @(posedge pclk);
    mode_sel0_readback_trigger <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({mode_sel1_oe, mode_sel1_readback_data_n}, {exp, 1'b1});
    i_ccp_partner.shift(32'h0, 16);
    chk(rb_seen, exp);
  endtask : t_rb
  task automatic t_after();
    reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(user_clear_n, 1'b0);
    reset_n <= 1'b1;
    power_down_n <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(outputs_active, 1'b0);
    power_down_n <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(done_program_oe, 1'b1);
    repeat (200) @(posedge pclk);
    // The restart resamples the mode lines; mode 2 low picks a master mode.
    dp_pull <= 1'b1;
    mode_sel2 <= 1'b0;
    repeat (10) @(posedge pclk);
    dp_pull <= 1'b0;
    wait_state(ST_CFG);
    chk(rd[6:0], {3'b011, 1'b1, ST_CFG});
    chk(config_clock_oe, 1'b1);
    wait_state(ST_USER);
    chk({outputs_active, done_program_oe, high_during_config}, 3'b100);
  endtask : t_after
  // Second power-on with mode 0 low: the long delay must still be running at 300 cycles.
  task automatic t_pon();
    presetn <= 1'b0;
    reset_n <= 1'b0;
    mode_sel0_readback_trigger <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    apb(1'b0, CCP_STATUS_ADDR, 32'h0);
    chk({rd[3:0], init_oe}, {1'b0, ST_PON, 1'b1});
    repeat (100) @(posedge pclk);
    apb(1'b0, CCP_STATUS_ADDR, 32'h0);
    chk({rd[2:0], init_oe}, {ST_WAIT, 1'b0});
  endtask : t_pon
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // Main sequence; options never, once twice, then repeat twice.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_boot();
    t_bad();
    t_load();
    t_rb(32'h0000_000c, 1'b0);
    t_rb(32'h0000_000a, 1'b1);
    t_rb(32'h0000_000a, 1'b0);
    t_rb(32'h0000_0008, 1'b1);
    t_rb(32'h0000_0008, 1'b1);
    t_after();
    t_pon();
    finish_test();
  end
endmodule : ccp_top_tb
